// *** verilog/eetw_device.sv ***
// Serial EEPROM two-wire slave engine with page buffer and storage array
`timescale 1ns/1ps
`default_nettype none
`include "eetw_regs.svh"

module eetw_device
    import eetw_pkg::*;
#(
    parameter int ADDR_W = `EETW_ADDR_W,
    parameter int PAGE_W = `EETW_PAGE_W,
    parameter int WR_CYC = `EETW_WR_TIME_MS * `EETW_CLK_KHZ
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    eetw_link_if.dev link,
    input wire logic select_pin_high_i,
    input wire logic select_pin_low_i,
    input wire logic write_protect_i,
    output logic write_busy_o,
    output logic standby_o
);

    localparam int PAGE_N = 1 << PAGE_W;
    localparam int MEM_N = 1 << ADDR_W;
    localparam int TW = $clog2(WR_CYC + 1);
    localparam logic [4:0] SYNC_RST = `EETW_SYNC_RST;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [4:0] raw;
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic [4:0] s3_reg;
    logic [4:0] f_reg;

    assign raw = {link.scl, link.sda, select_pin_high_i, select_pin_low_i, write_protect_i};

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_sync
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                begin
                    s1_reg[g] <= SYNC_RST[g];
                    s2_reg[g] <= SYNC_RST[g];
                    s3_reg[g] <= SYNC_RST[g];
                    f_reg[g] <= SYNC_RST[g];
                end
                else
                begin
                    s1_reg[g] <= raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    // Glitch filter: accept only a level seen twice
                    if (s2_reg[g] == s3_reg[g])
                        f_reg[g] <= s2_reg[g];
                end
            end
        end
    endgenerate

    wire scl_f = f_reg[4];
    wire sda_f = f_reg[3];
    wire sel_hi_f = f_reg[2];
    wire sel_lo_f = f_reg[1];
    wire wp_f = f_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Bus event detection
    logic scl_d_reg;
    logic sda_d_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_f;
            sda_d_reg <= sda_f;
        end
    end

    wire scl_rise = scl_f & ~scl_d_reg;
    wire scl_fall = ~scl_f & scl_d_reg;
    wire start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
    wire stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
    wire ev_ok = ~start_det & ~stop_det;

    ////////////////////////////////////////////////////////////////////////
    // Protocol state
    eetw_dev_state_t state_reg;
    eetw_dev_state_t state_next;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic ack_ph_reg;
    logic sda_oe_reg;
    logic host_ack_reg;
    logic busy_reg;
    logic give_ack;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] ahi_reg;
    logic [7:0] mem [MEM_N];

    wire rx_st = (state_reg == ds_dev) | (state_reg == ds_ahi) | (state_reg == ds_alo) | (state_reg == ds_wdat);
    wire rd_st = (state_reg == ds_rdat);
    wire byte_done = ev_ok & scl_fall & rx_st & ~ack_ph_reg & (cnt_reg == `EETW_BYTE_BITS);
    wire prefix_ok = (sh_reg[7:3] == `EETW_DEV_PREFIX);
    wire sel_ok = (sh_reg[2] == sel_hi_f) & (sh_reg[1] == sel_lo_f);
    wire dev_hit = prefix_ok & sel_ok & ~busy_reg;
    wire ack_fall = ev_ok & scl_fall & ack_ph_reg;
    wire rd_fall = ev_ok & scl_fall & rd_st & ~ack_ph_reg;
    wire rd_rise = ev_ok & scl_rise & rd_st;
    wire load_rd = (ack_fall & rd_st) | (rd_fall & (cnt_reg == `EETW_ACK_CLK) & host_ack_reg);
    wire [7:0] rd_byte = mem[addr_reg];

    always_comb
    begin
        state_next = state_reg;
        give_ack = 1'b1;
        case (state_reg)
            ds_dev:
            begin
                if (!dev_hit)
                begin
                    state_next = ds_idle;
                    give_ack = 1'b0;
                end
                else if (sh_reg[0])
                    state_next = ds_rdat;
                else
                    state_next = ds_ahi;
            end
            ds_ahi: state_next = ds_alo;
            ds_alo: state_next = ds_wdat;
            ds_wdat: state_next = ds_wdat;
            default: state_next = ds_idle;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ds_idle;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ack_ph_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            host_ack_reg <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg <= ds_dev;
            cnt_reg <= 4'h0;
            ack_ph_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= ds_idle;
            cnt_reg <= 4'h0;
            ack_ph_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (byte_done)
        begin
            state_reg <= state_next;
            ack_ph_reg <= give_ack;
            sda_oe_reg <= give_ack;
            cnt_reg <= 4'h0;
        end
        else if (load_rd)
        begin
            ack_ph_reg <= 1'b0;
            sh_reg <= rd_byte;
            sda_oe_reg <= ~rd_byte[7];
            cnt_reg <= 4'h0;
        end
        else if (ack_fall)
        begin
            ack_ph_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (ev_ok & scl_rise & rx_st & ~ack_ph_reg)
        begin
            sh_reg <= {sh_reg[6:0], sda_f};
            cnt_reg <= cnt_reg + 4'h1;
        end
        else if (rd_rise)
        begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `EETW_BYTE_BITS)
                host_ack_reg <= ~sda_f;
        end
        else if (rd_fall)
        begin
            if (cnt_reg < `EETW_BYTE_BITS)
            begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_oe_reg <= ~sh_reg[6];
            end
            else if (cnt_reg == `EETW_BYTE_BITS)
                sda_oe_reg <= 1'b0;
            else
                state_reg <= ds_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address counter and page buffer
    logic [7:0] pbuf [PAGE_N];
    logic [PAGE_N-1:0] pvalid_reg;
    logic [ADDR_W-PAGE_W-1:0] page_reg;
    logic [PAGE_W:0] cidx_reg;
    logic [TW-1:0] tmr_reg;

    wire [15:0] word_addr = {ahi_reg, sh_reg};
    wire wbyte = byte_done & (state_reg == ds_wdat);
    wire [PAGE_W-1:0] addr_low = addr_reg[PAGE_W-1:0];
    wire [PAGE_W-1:0] addr_low_inc = addr_low + 1'b1;
    wire wr_go = stop_det & (state_reg == ds_wdat) & (|pvalid_reg) & ~wp_f & ~busy_reg;
    wire commit_en = busy_reg & ~cidx_reg[PAGE_W];
    wire [PAGE_W-1:0] cidx = cidx_reg[PAGE_W-1:0];

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            addr_reg <= '0;
            ahi_reg <= 8'h00;
            page_reg <= '0;
            pvalid_reg <= '0;
        end
        else if (byte_done & (state_reg == ds_ahi))
            ahi_reg <= sh_reg;
        else if (byte_done & (state_reg == ds_alo))
        begin
            addr_reg <= word_addr[ADDR_W-1:0];
            page_reg <= word_addr[ADDR_W-1:PAGE_W];
            pvalid_reg <= '0;
        end
        else if (wbyte)
        begin
            pvalid_reg[addr_low] <= 1'b1;
            addr_reg <= {addr_reg[ADDR_W-1:PAGE_W], addr_low_inc};
        end
        else if (load_rd)
            addr_reg <= addr_reg + 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (wbyte)
            pbuf[addr_low] <= sh_reg;
    end

    // Bytes go to the array one per cycle inside the timed cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (commit_en & pvalid_reg[cidx])
            mem[{page_reg, cidx}] <= pbuf[cidx];
    end

    ////////////////////////////////////////////////////////////////////////
    // Timed write cycle and status
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            busy_reg <= 1'b0;
            tmr_reg <= '0;
            cidx_reg <= '0;
        end
        else if (wr_go)
        begin
            busy_reg <= 1'b1;
            tmr_reg <= '0;
            cidx_reg <= '0;
        end
        else if (busy_reg)
        begin
            tmr_reg <= tmr_reg + 1'b1;
            if (commit_en)
                cidx_reg <= cidx_reg + 1'b1;
            if (tmr_reg == TW'(WR_CYC - 1))
                busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            write_busy_o <= 1'b0;
            standby_o <= 1'b1;
        end
        else
        begin
            write_busy_o <= busy_reg;
            standby_o <= (state_reg == ds_idle) & ~busy_reg;
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe_reg;

endmodule : eetw_device
`default_nettype wire

// *** verilog/eetw_regs.svh ***
// Constants of the two-wire serial EEPROM slave and its bus controller
`ifndef EETW_REGS_SVH
`define EETW_REGS_SVH

// Clock and timing
`define EETW_CLK_KHZ 25000
`define EETW_CLK_NS 40
`define EETW_WR_TIME_MS 10
`define EETW_SCL_QTR_NS 2500

// Array organisation
`define EETW_ADDR_W 15
`define EETW_PAGE_W 6

// Device address word and clock counts
`define EETW_DEV_PREFIX 5'h14
`define EETW_BYTE_BITS 4'h8
`define EETW_ACK_CLK 4'h9
`define EETW_RECOV_LAST 4'h8

// Synchroniser reset levels: scl, sda, high select, low select, protect
`define EETW_SYNC_RST 5'h18

// Controller register map (byte addresses)
`define EETW_OFS_CMD 4'h0
`define EETW_OFS_STAT 4'h4
`define EETW_OFS_RX 4'h8

// Command register fields and codes
`define EETW_CMD_ACK_BIT 3
`define EETW_CMD_TX_LSB 8
`define EETW_CMD_START 3'h1
`define EETW_CMD_STOP 3'h2
`define EETW_CMD_WRITE 3'h3
`define EETW_CMD_READ 3'h4
`define EETW_CMD_RECOVER 3'h5

`endif

// *** verilog/eetw_pkg.sv ***
// Types shared by both ends of the two-wire EEPROM link
`default_nettype none
package eetw_pkg;

    typedef enum logic [5:0] {
        ds_idle = 6'h01,
        ds_dev  = 6'h02,
        ds_ahi  = 6'h04,
        ds_alo  = 6'h08,
        ds_wdat = 6'h10,
        ds_rdat = 6'h20
    } eetw_dev_state_t;

    typedef enum logic [4:0] {
        hs_idle  = 5'h01,
        hs_start = 5'h02,
        hs_bit   = 5'h04,
        hs_stop  = 5'h08,
        hs_recov = 5'h10
    } eetw_host_state_t;

endpackage : eetw_pkg
`default_nettype wire

// *** verilog/eetw_link_if.sv ***
// Two-wire link between controller and EEPROM, with wired-AND data line
`timescale 1ns/1ps
`default_nettype none
interface eetw_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open drain with pull-up: any enabled low driver wins
    assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : eetw_link_if
`default_nettype wire

// *** verilog/eetw_host.sv ***
// Two-wire bus controller: software commands drive start, stop and byte transfers
`timescale 1ns/1ps
`default_nettype none
`include "eetw_regs.svh"

module eetw_host
    import eetw_pkg::*;
#(
    parameter int QTR_CYC = (`EETW_SCL_QTR_NS + `EETW_CLK_NS - 1) / `EETW_CLK_NS
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    eetw_link_if.host link,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_stb_i,
    input wire logic rd_stb_i,
    output logic [31:0] rd_data_o
);

    localparam int DW = $clog2(QTR_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Data line synchroniser
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic sda_f_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            sda_f_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= link.sda;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                sda_f_reg <= s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Quarter-bit divider
    eetw_host_state_t st_reg;
    logic [DW-1:0] div_reg;

    wire tick = (st_reg != hs_idle) & (div_reg == DW'(QTR_CYC - 1));

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || st_reg == hs_idle || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode and bit engine
    logic [1:0] q_reg;
    logic [3:0] cnt_reg;
    logic [8:0] tx_reg;
    logic [8:0] rx_reg;
    logic scl_reg;
    logic oe_reg;
    logic nack_reg;
    logic stuck_reg;
    logic [7:0] rxbyte_reg;

    wire cmd_wr = wr_stb_i & (addr_i == `EETW_OFS_CMD) & (st_reg == hs_idle);
    wire [2:0] cmd = wr_data_i[2:0];
    wire ack_bit = wr_data_i[`EETW_CMD_ACK_BIT];
    wire [7:0] tx_byte = wr_data_i[`EETW_CMD_TX_LSB +: 8];
    wire last_bit = (cnt_reg == `EETW_BYTE_BITS);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_reg <= hs_idle;
            q_reg <= 2'h0;
            cnt_reg <= 4'h0;
            tx_reg <= 9'h1ff;
            rx_reg <= 9'h000;
            scl_reg <= 1'b1;
            oe_reg <= 1'b0;
            nack_reg <= 1'b0;
            stuck_reg <= 1'b0;
            rxbyte_reg <= 8'h00;
        end
        else if (cmd_wr)
        begin
            q_reg <= 2'h0;
            cnt_reg <= 4'h0;
            case (cmd)
                `EETW_CMD_START: st_reg <= hs_start;
                `EETW_CMD_STOP: st_reg <= hs_stop;
                `EETW_CMD_WRITE:
                begin
                    st_reg <= hs_bit;
                    tx_reg <= {tx_byte, 1'b1};
                end
                `EETW_CMD_READ:
                begin
                    st_reg <= hs_bit;
                    tx_reg <= {8'hff, ~ack_bit};
                end
                `EETW_CMD_RECOVER:
                begin
                    st_reg <= hs_recov;
                    stuck_reg <= 1'b0;
                end
                default: st_reg <= hs_idle;
            endcase
        end
        else if (tick)
        begin
            q_reg <= q_reg + 2'h1;
            case (st_reg)
                hs_start:
                begin
                    // Release data, raise clock, pull data low, lower clock
                    case (q_reg)
                        2'h0: oe_reg <= 1'b0;
                        2'h1: scl_reg <= 1'b1;
                        2'h2: oe_reg <= 1'b1;
                        default:
                        begin
                            scl_reg <= 1'b0;
                            st_reg <= hs_idle;
                        end
                    endcase
                end
                hs_stop:
                begin
                    case (q_reg)
                        2'h0: oe_reg <= 1'b1;
                        2'h1: scl_reg <= 1'b1;
                        2'h2: oe_reg <= 1'b0;
                        default: st_reg <= hs_idle;
                    endcase
                end
                hs_bit:
                begin
                    case (q_reg)
                        2'h0: oe_reg <= ~tx_reg[8];
                        2'h1: scl_reg <= 1'b1;
                        2'h2: rx_reg <= {rx_reg[7:0], sda_f_reg};
                        default:
                        begin
                            scl_reg <= 1'b0;
                            tx_reg <= {tx_reg[7:0], 1'b1};
                            cnt_reg <= cnt_reg + 4'h1;
                            if (last_bit)
                            begin
                                st_reg <= hs_idle;
                                rxbyte_reg <= rx_reg[8:1];
                                nack_reg <= rx_reg[0];
                            end
                        end
                    endcase
                end
                hs_recov:
                begin
                    case (q_reg)
                        2'h0: oe_reg <= 1'b0;
                        2'h1: scl_reg <= 1'b1;
                        2'h2:
                        begin
                            // Line free: go straight on to a start
                            if (sda_f_reg)
                            begin
                                st_reg <= hs_start;
                                q_reg <= 2'h0;
                            end
                        end
                        default:
                        begin
                            scl_reg <= 1'b0;
                            cnt_reg <= cnt_reg + 4'h1;
                            if (cnt_reg == `EETW_RECOV_LAST)
                            begin
                                st_reg <= hs_start;
                                stuck_reg <= 1'b1;
                            end
                        end
                    endcase
                end
                default: st_reg <= hs_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    wire [31:0] stat_word = {29'h0, stuck_reg, nack_reg, st_reg != hs_idle};
    wire [31:0] rd_mux = (addr_i == `EETW_OFS_STAT) ? stat_word :
                         (addr_i == `EETW_OFS_RX) ? {24'h0, rxbyte_reg} : 32'h0;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || !rd_stb_i)
            rd_data_o <= 32'h0;
        else
            rd_data_o <= rd_mux;
    end

    assign link.scl = scl_reg;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = oe_reg;

endmodule : eetw_host
`default_nettype wire

// *** dv/eetw_chk.sv ***
// Link checker for the two-wire EEPROM ends
`timescale 1ns/1ps
`default_nettype none
module eetw_chk #(
    parameter int WR_CYC = 200
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic select_pin_high_i,
    input wire logic select_pin_low_i,
    input wire logic write_busy_o,
    input wire logic standby_o
);
    localparam int BUSY_HI = WR_CYC + 8;
    logic scl_q, sda_q, acked_wr, acked_rd;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic [7:0] sh;
    wire rise_w = scl & ~scl_q;
    wire start_w = scl & scl_q & sda_q & ~sda;
    wire stop_w = scl & scl_q & ~sda_q & sda;
    wire match_w = (sh[7:3] == 5'h14) & (sh[2:1] == {select_pin_high_i, select_pin_low_i});
    wire last_w = rise_w & (cnt == 4'h8);

    ////////////////////////////////////////////////////////////////////////
    // Bit and byte position within a frame, counted on the wire itself
    always_ff @(posedge ref_clk_i)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (!rst_n_i || start_w)
        begin
            cnt <= 4'h0;
            idx <= 2'h0;
            acked_wr <= 1'b0;
            acked_rd <= 1'b0;
        end
        else if (rise_w)
        begin
            sh <= {sh[6:0], sda};
            cnt <= last_w ? 4'h0 : cnt + 4'h1;
            if (last_w && idx != 2'h3)
                idx <= idx + 2'h1;
            if (last_w && idx == 2'h0)
            begin
                acked_wr <= dev_sda_oe & ~sh[0];
                acked_rd <= dev_sda_oe & sh[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_reset_idle;
        $rose(rst_n_i) |-> !dev_sda_oe && standby_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("device active after reset");
    property p_change_low;
        $changed(dev_sda_oe) |-> !scl;
    endproperty
    a_change_low: assert property (p_change_low) else $error("device data moved with clock high");
    property p_addr_quiet;
        rise_w && idx == 2'h0 && cnt < 4'h8 |-> !dev_sda_oe;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address bits");
    property p_addr_ack;
        last_w && idx == 2'h0 |-> dev_sda_oe == (match_w && !write_busy_o);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("wrong address acknowledge");
    property p_data_ack;
        last_w && idx != 2'h0 && (acked_wr || acked_rd) |-> dev_sda_oe == acked_wr;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("wrong ninth bit drive");
    property p_busy_standby;
        write_busy_o |-> !standby_o;
    endproperty
    a_busy_standby: assert property (p_busy_standby) else $error("standby during write cycle");
    property p_busy_span;
        $rose(write_busy_o) |-> ##[1:BUSY_HI] !write_busy_o;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("write cycle too long");
    property p_stop_standby;
        stop_w && !write_busy_o |-> ##[1:12] (standby_o || write_busy_o);
    endproperty
    a_stop_standby: assert property (p_stop_standby) else $error("no standby after stop");
endmodule : eetw_chk
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench: controller and EEPROM ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic wp = 1'b0;
    logic busy, stby;
    logic [31:0] rd_data, st, d;
    int n_mismatch = 0;
    int check_count = 0;

    always #20 clk = ~clk;
    eetw_link_if link ();
    eetw_device #(.WR_CYC(600)) eetw_device_i (.ref_clk_i(clk), .rst_n_i(rst_n), .link(link),
        .select_pin_high_i(sel_hi), .select_pin_low_i(sel_lo), .write_protect_i(wp),
        .write_busy_o(busy), .standby_o(stby));
    eetw_host #(.QTR_CYC(8)) eetw_host_i (.ref_clk_i(clk), .rst_n_i(rst_n), .link(link), .addr_i(addr),
        .wr_data_i(wdat), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .rd_data_o(rd_data));
    eetw_chk #(.WR_CYC(600)) eetw_chk_i (.ref_clk_i(clk), .rst_n_i(rst_n), .scl(link.scl), .sda(link.sda),
        .dev_sda_oe(link.dev_sda_oe), .select_pin_high_i(sel_hi), .select_pin_low_i(sel_lo),
        .write_busy_o(busy), .standby_o(stby));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Extra edge after each strobe keeps strobes one cycle with no double drive
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        addr <= a;
        wdat <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        d = rd_data;
    endtask : bus_rd
    task automatic cmd(input logic [2:0] code, input logic [7:0] b, input logic ack);
        int n;
        bus_wr(4'h0, {16'h0, b, 4'h0, ack, code});
        st = 32'h1;
        for (n = 0; n < 2000 && st[0] !== 1'b0; n++)
        begin
            bus_rd(4'h4);
            st = d;
        end
        check("cmd done", 32'h0, {31'h0, st[0]});
    endtask : cmd
    task automatic snd(input logic [7:0] b, input logic nack);
        cmd(3'h3, b, 1'b0);
        check("nack", {31'h0, nack}, {31'h0, st[1]});
    endtask : snd
    task automatic rdb(input logic ack, input logic [7:0] exp);
        cmd(3'h4, 8'h00, ack);
        bus_rd(4'h8);
        check("rx byte", {24'h0, exp}, d);
    endtask : rdb
    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha0, 1'b0);
        snd(hi, 1'b0);
        snd(lo, 1'b0);
    endtask : set_addr
    task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo);
        set_addr(hi, lo);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha1, 1'b0);
    endtask : rd_at
    task automatic wait_busy(input logic exp);
        int n;
        for (n = 0; n < 20 && busy !== 1'b1; n++)
            @(posedge clk);
        check("busy", {31'h0, exp}, {31'h0, busy});
    endtask : wait_busy
    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++)
            @(posedge clk);
        check("idle", 32'h0, {31'h0, busy});
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus_rd(4'h4);
        check("status", 32'h0, d);
        bus_rd(4'hc);
        check("unmapped", 32'h0, d);
        check("standby", 32'h1, {31'h0, stby});
        check("line idle", 32'h3, {30'h0, link.scl, link.sda});
        $display("reset test done");
    endtask : t_reset
    task automatic t_byte_poll();
        set_addr(8'h80, 8'h00);
        snd(8'h55, 1'b0);
        cmd(3'h2, 8'h00, 1'b0);
        wait_busy(1'b1);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha0, 1'b1);
        cmd(3'h2, 8'h00, 1'b0);
        wait_idle();
        rd_at(8'h00, 8'h00);
        rdb(1'b0, 8'h55);
        cmd(3'h2, 8'h00, 1'b0);
        $display("byte write and poll test done");
    endtask : t_byte_poll
    task automatic t_page();
        int i;
        set_addr(8'h01, 8'h3e);
        for (i = 0; i < 4; i++)
            snd(8'h10 + 8'(i), 1'b0);
        cmd(3'h2, 8'h00, 1'b0);
        wait_busy(1'b1);
        wait_idle();
        rd_at(8'h01, 8'h00);
        rdb(1'b0, 8'h12);
        cmd(3'h2, 8'h00, 1'b0);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha1, 1'b0);
        rdb(1'b0, 8'h13);
        cmd(3'h2, 8'h00, 1'b0);
        rd_at(8'h01, 8'h3e);
        rdb(1'b1, 8'h10);
        rdb(1'b0, 8'h11);
        cmd(3'h2, 8'h00, 1'b0);
        $display("page write test done");
    endtask : t_page
    task automatic t_wrap();
        set_addr(8'h7f, 8'hff);
        snd(8'ha5, 1'b0);
        cmd(3'h2, 8'h00, 1'b0);
        wait_busy(1'b1);
        wait_idle();
        rd_at(8'hff, 8'hff);
        rdb(1'b1, 8'ha5);
        rdb(1'b0, 8'h55);
        cmd(3'h2, 8'h00, 1'b0);
        $display("read wrap test done");
    endtask : t_wrap
    task automatic t_select();
        sel_hi <= 1'b1;
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha0, 1'b1);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'hb4, 1'b1);
        cmd(3'h1, 8'h00, 1'b0);
        snd(8'ha4, 1'b0);
        snd(8'h00, 1'b0);
        cmd(3'h2, 8'h00, 1'b0);
        sel_hi <= 1'b0;
        $display("select test done");
    endtask : t_select
    task automatic t_protect();
        wp <= 1'b1;
        set_addr(8'h00, 8'h00);
        snd(8'h99, 1'b0);
        cmd(3'h2, 8'h00, 1'b0);
        wait_busy(1'b0);
        wp <= 1'b0;
        rd_at(8'h00, 8'h00);
        rdb(1'b0, 8'h55);
        cmd(3'h2, 8'h00, 1'b0);
        cmd(3'h5, 8'h00, 1'b0);
        check("recover stuck", 32'h0, {31'h0, st[2]});
        $display("protect and recover test done");
    endtask : t_protect
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_byte_poll();
        t_page();
        t_wrap();
        t_select();
        t_protect();
        test_done();
    end
    // Whole run is near 18000 cycles; over three times that means a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
